// [shared/sie_status_pkg.sv]
package eng_status_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  CTRL_STATUS_OFFSET    = 8'h04;
    localparam logic [7:0]  ADDRESS_OFFSET        = 8'h06;
    localparam logic [7:0]  INT_STATUS_OFFSET     = 8'h08;
    localparam logic [7:0]  EVENT_OFFSET          = 8'h0C;
    localparam logic [15:0] CTRL_STATUS_RESET     = 16'h0000;
    localparam logic [15:0] ADDRESS_RESET         = 16'h0000;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int J_LINE_BIT       = 15;
    localparam int SE0_BIT          = 14;
    localparam int HOLD_BIT         = 13;
    localparam int BUS_RESET_BIT    = 12;
    localparam int HOST_BIT         = 11;
    localparam int RESUME_BIT       = 10;
    localparam int ODD_CLEAR_BIT    = 9;
    localparam int ENABLE_BIT       = 8;
    localparam int ENDPOINT_LSB     = 4;
    localparam int TX_BIT           = 3;
    localparam int ODD_BIT          = 2;
    localparam int LOW_SPEED_BIT    = 7;
    localparam int DONE_BIT         = 3;

    // ****************************************************************
    // timing and sizes
    // ****************************************************************
    localparam int STATUS_DEPTH     = 4;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int LS_EOP_NS        = 1330;
    localparam int LS_EOP_CYCLES    = LS_EOP_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        RES_IDLE,
        RES_DRIVE,
        RES_EOP
    } resume_state_t;

endpackage : eng_status_pkg

// [rtl/status_fifo.sv]
`timescale 1ns/1ps
module status_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic             flush_in,
    // write side
    input  wire logic             push_valid_in,
    output logic                  push_ready_out,
    input  wire logic [WIDTH-1:0] push_data_in,
    // read side
    output logic                  pop_valid_out,
    input  wire logic             pop_ready_in,
    output logic      [WIDTH-1:0] pop_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("status_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [AW-1:0]    rd_ff, nxt_rd, wr_ff, nxt_wr;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             do_push, do_pop;

    assign push_ready_out = (cnt_ff != DEPTH[AW:0]);
    assign pop_valid_out  = (cnt_ff != '0);
    assign pop_data_out   = mem_ff[rd_ff];

    always_comb
    begin
        do_push = push_valid_in && push_ready_out;
        do_pop  = pop_valid_out && pop_ready_in;
        nxt_mem = mem_ff;
        nxt_rd  = rd_ff;
        nxt_wr  = wr_ff;
        nxt_cnt = cnt_ff;
        if (flush_in)
        begin
            nxt_rd  = '0;
            nxt_wr  = '0;
            nxt_cnt = '0;
        end
        else
        begin
            if (do_push)
            begin
                nxt_mem[wr_ff] = push_data_in;
                nxt_wr = wr_ff + 1'b1;
            end
            if (do_pop)
                nxt_rd = rd_ff + 1'b1;
            if (do_push && !do_pop)
                nxt_cnt = cnt_ff + 1'b1;
            else if (do_pop && !do_push)
                nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_ff[i] <= '0;
            rd_ff  <= '0;
            wr_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            mem_ff <= nxt_mem;
            rd_ff  <= nxt_rd;
            wr_ff  <= nxt_wr;
            cnt_ff <= nxt_cnt;
        end
    end

endmodule : status_fifo

// [rtl/sie_control_status.sv]
//
// Function
// - status byte valid whenever done flag set
// - status queue is four entries deep
// - later transactions queue, current entry stays
// - clearing done flag advances status window
// - queued entry re-raises done flag after a one-cycle drop
// - bit 15 live J state, speed polarity
// - bit 14 live SE0, not latched
// - peripheral setup sets hold, stops traffic
// - host mode: bit 13 busy during token
// - bit 12 drives bus reset in host
// - bit 11 selects host role
// - bit 10 resume; host adds LS EOP
// - writing bit 9 clears ping-pong bits
// - bit 8 enables engine, clear resets it
// - entry bits 7:4 last endpoint
// - entry bit 3 transmit versus receive
// - entry bit 2 odd bank
// - low speed bit sets J polarity
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module eng_control_status
    import eng_status_pkg::*;
#(
    parameter int NUM_ENDPOINTS = 16
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // bus line receiver (pins)
    input  wire logic        line_dp_in,
    input  wire logic        line_dm_in,
    // transaction completions from the serial engine
    input  wire logic        txn_done_in,
    input  wire logic [3:0]  txn_endpoint_in,
    input  wire logic        txn_tx_in,
    input  wire logic        txn_odd_in,
    output logic             txn_ready_out,
    // token events
    input  wire logic        setup_rx_in,
    input  wire logic        token_start_in,
    input  wire logic        token_end_in,
    // engine controls
    output logic             engine_enable_out,
    output logic             host_role_select_out,
    output logic             drive_bus_reset_out,
    output logic             drive_resume_out,
    output logic             drive_ls_eop_out,
    output logic             traffic_halt_out,
    output logic             sof_enable_out,
    output logic             low_speed_select_out,
    output logic [NUM_ENDPOINTS-1:0] odd_bank_out
);

    if (NUM_ENDPOINTS < 1 || NUM_ENDPOINTS > 16)
    begin : g_bad_endpoints
        $error("NUM_ENDPOINTS must be 1..16");
    end

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_ff, rst_sync_ff;

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ****************************************************************
    // line pin synchronisers
    // ****************************************************************
    logic [1:0] line_meta_ff, line_ff;

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            line_meta_ff <= 2'h0;
            line_ff      <= 2'h0;
        end
        else
        begin
            line_meta_ff <= {line_dp_in, line_dm_in};
            line_ff      <= line_meta_ff;
        end
    end

    // ****************************************************************
    // apb decode
    // ****************************************************************
    logic apb_wr, apb_rd, hit_ctrl, hit_addr, hit_int, hit_evt, hit_any;

    assign hit_ctrl    = (paddr_in == CTRL_STATUS_OFFSET);
    assign hit_addr    = (paddr_in == ADDRESS_OFFSET);
    assign hit_int     = (paddr_in == INT_STATUS_OFFSET);
    assign hit_evt     = (paddr_in == EVENT_OFFSET);
    assign hit_any     = hit_ctrl | hit_addr | hit_int | hit_evt;
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !hit_any;
    assign apb_wr      = psel_in && penable_in && pwrite_in && hit_any;
    assign apb_rd      = psel_in && !penable_in && !pwrite_in;

    // ****************************************************************
    // control state
    // ****************************************************************
    logic       enable_ff, nxt_enable;
    logic       host_ff, nxt_host;
    logic       bus_reset_ff, nxt_bus_reset;
    logic       resume_ff, nxt_resume;
    logic       low_speed_ff, nxt_low_speed;
    logic       hold_ff, nxt_hold;
    logic       busy_ff, nxt_busy;
    logic       done_ff, nxt_done;
    logic [NUM_ENDPOINTS-1:0] odd_ff, nxt_odd;
    resume_state_t res_ff, nxt_res;
    logic [15:0] eop_cnt_ff, nxt_eop_cnt;
    logic [31:0] prdata_ff, nxt_prdata;

    // status queue: window entry is the head of the fifo
    logic       q_valid;
    logic       q_pop;
    logic [5:0] q_head;
    logic       done_clear;
    logic       wr_ctrl;

    assign wr_ctrl    = apb_wr && hit_ctrl;
    assign done_clear = apb_wr && hit_int && pwdata_in[DONE_BIT];
    // window advances only when software clears a raised flag
    assign q_pop      = done_clear && done_ff;

    status_fifo #(
        .WIDTH (6),
        .DEPTH (STATUS_DEPTH)
    ) u_status_fifo (
        .clk_sys_in     (clk_sys_in),
        .rst_n_in       (rst_sync_ff),
        .flush_in       (!enable_ff),
        .push_valid_in  (txn_done_in && enable_ff),
        .push_ready_out (txn_ready_out),
        .push_data_in   ({txn_endpoint_in, txn_tx_in, txn_odd_in}),
        .pop_valid_out  (q_valid),
        .pop_ready_in   (q_pop),
        .pop_data_out   (q_head)
    );

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    logic [15:0] ctrl_word;
    logic        j_state;

    // J is D+ high at full speed and D- high at low speed
    assign j_state = low_speed_ff ? line_ff[0] : line_ff[1];

    always_comb
    begin
        ctrl_word = 16'h0000;
        ctrl_word[J_LINE_BIT]    = j_state;
        ctrl_word[SE0_BIT]       = (line_ff == 2'h0);
        ctrl_word[HOLD_BIT]      = host_ff ? busy_ff : hold_ff;
        ctrl_word[BUS_RESET_BIT] = bus_reset_ff;
        ctrl_word[HOST_BIT]      = host_ff;
        ctrl_word[RESUME_BIT]    = resume_ff;
        ctrl_word[ENABLE_BIT]    = enable_ff;
        if (done_ff)
        begin
            ctrl_word[ENDPOINT_LSB +: 4] = q_head[5:2];
            ctrl_word[TX_BIT]            = q_head[1];
            ctrl_word[ODD_BIT]           = q_head[0];
        end
        // bits 1:0 stay zero
    end

    always_comb
    begin
        nxt_enable    = enable_ff;
        nxt_host      = host_ff;
        nxt_bus_reset = bus_reset_ff;
        nxt_resume    = resume_ff;
        nxt_low_speed = low_speed_ff;
        nxt_hold      = hold_ff;
        nxt_busy      = busy_ff;
        nxt_odd       = odd_ff;
        nxt_res       = res_ff;
        nxt_eop_cnt   = eop_cnt_ff;
        nxt_prdata    = prdata_ff;

        if (wr_ctrl)
        begin
            nxt_enable    = pwdata_in[ENABLE_BIT];
            nxt_host      = pwdata_in[HOST_BIT];
            nxt_bus_reset = pwdata_in[BUS_RESET_BIT];
            nxt_resume    = pwdata_in[RESUME_BIT];
            if (!pwdata_in[HOLD_BIT])
                nxt_hold = 1'b0;
        end
        if (apb_wr && hit_addr)
            nxt_low_speed = pwdata_in[LOW_SPEED_BIT];

        // setup arrival wins over a simultaneous clear
        if (setup_rx_in && !host_ff && enable_ff)
            nxt_hold = 1'b1;

        if (token_start_in && host_ff && enable_ff)
            nxt_busy = 1'b1;
        else if (token_end_in)
            nxt_busy = 1'b0;

        if (wr_ctrl && pwdata_in[ODD_CLEAR_BIT])
            nxt_odd = '0;
        else if (txn_done_in && enable_ff && txn_ready_out)
            nxt_odd[txn_endpoint_in[3:0] % NUM_ENDPOINTS] =
                ~odd_ff[txn_endpoint_in[3:0] % NUM_ENDPOINTS];

        // disabling the engine resets its ping-pong and token state
        if (!nxt_enable)
        begin
            nxt_odd  = '0;
            nxt_hold = 1'b0;
            nxt_busy = 1'b0;
        end

        case (res_ff)
            RES_IDLE:
                if (nxt_resume)
                    nxt_res = RES_DRIVE;
            RES_DRIVE:
                if (!resume_ff)
                begin
                    nxt_eop_cnt = 16'(LS_EOP_CYCLES);
                    nxt_res = host_ff ? RES_EOP : RES_IDLE;
                end
            RES_EOP:
                if (eop_cnt_ff <= 16'h0001)
                    nxt_res = RES_IDLE;
                else
                    nxt_eop_cnt = eop_cnt_ff - 16'h0001;
            default:
                nxt_res = RES_IDLE;
        endcase

        if (apb_rd)
        begin
            nxt_prdata = 32'h0000_0000;
            if (hit_ctrl)
                nxt_prdata[15:0] = ctrl_word;
            else if (hit_addr)
                nxt_prdata[LOW_SPEED_BIT] = low_speed_ff;
            else if (hit_int)
                nxt_prdata[DONE_BIT] = done_ff;
        end
    end

    // a pop drops the done flag for one cycle and a waiting entry raises
    // it again on the next, so a popped entry is never shown as valid
    always_comb
    begin
        nxt_done = q_valid;
        if (q_pop || !enable_ff)
            nxt_done = 1'b0;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            enable_ff    <= CTRL_STATUS_RESET[ENABLE_BIT];
            host_ff      <= CTRL_STATUS_RESET[HOST_BIT];
            bus_reset_ff <= CTRL_STATUS_RESET[BUS_RESET_BIT];
            resume_ff    <= CTRL_STATUS_RESET[RESUME_BIT];
            low_speed_ff <= ADDRESS_RESET[LOW_SPEED_BIT];
            hold_ff      <= CTRL_STATUS_RESET[HOLD_BIT];
            busy_ff      <= CTRL_STATUS_RESET[HOLD_BIT];
            done_ff      <= 1'b0;
            odd_ff       <= '0;
            res_ff       <= RES_IDLE;
            eop_cnt_ff   <= 16'h0000;
            prdata_ff    <= 32'h0000_0000;
        end
        else
        begin
            enable_ff    <= nxt_enable;
            host_ff      <= nxt_host;
            bus_reset_ff <= nxt_bus_reset;
            resume_ff    <= nxt_resume;
            low_speed_ff <= nxt_low_speed;
            hold_ff      <= nxt_hold;
            busy_ff      <= nxt_busy;
            done_ff      <= nxt_done;
            odd_ff       <= nxt_odd;
            res_ff       <= nxt_res;
            eop_cnt_ff   <= nxt_eop_cnt;
            prdata_ff    <= nxt_prdata;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata_out           = prdata_ff;
    assign engine_enable_out    = enable_ff;
    assign host_role_select_out = host_ff;
    assign drive_bus_reset_out  = bus_reset_ff && host_ff;
    assign drive_resume_out     = resume_ff;
    assign drive_ls_eop_out     = (res_ff == RES_EOP);
    assign traffic_halt_out     = hold_ff && !host_ff;
    assign sof_enable_out       = enable_ff && host_ff;
    assign low_speed_select_out = low_speed_ff;
    assign odd_bank_out         = odd_ff;

endmodule : eng_control_status

// [bench/sie_ctrl_chk.sv]
`timescale 1ns/1ps
module eng_ctrl_chk #(
    parameter int NUM_ENDPOINTS = 16
) (
    // clock, reset and apb
    input wire logic                     clk_sys_in,
    input wire logic                     reset_n_in,
    input wire logic                     psel_in,
    input wire logic                     penable_in,
    input wire logic                     pwrite_in,
    input wire logic [7:0]               paddr_in,
    input wire logic [31:0]              pwdata_in,
    input wire logic [31:0]              prdata_out,
    // engine side
    input wire logic                     txn_done_in,
    input wire logic                     setup_rx_in,
    input wire logic                     txn_ready_out,
    input wire logic                     engine_enable_out,
    input wire logic                     host_role_select_out,
    input wire logic                     drive_bus_reset_out,
    input wire logic                     drive_resume_out,
    input wire logic                     drive_ls_eop_out,
    input wire logic                     traffic_halt_out,
    input wire logic                     sof_enable_out,
    input wire logic                     low_speed_select_out,
    input wire logic [NUM_ENDPOINTS-1:0] odd_bank_out
);
    // ********
    // queue occupancy shadow
    // ********
    localparam int EOP_LO = 125;
    localparam int EOP_HI = 140;
    logic [2:0] occ_ff;
    logic [2:0] nxt_occ;
    logic       done_sh_ff, nxt_done_sh;
    wire logic wr_acc = psel_in && penable_in && pwrite_in;
    wire logic wr_ctl = wr_acc && paddr_in == 8'h04;
    wire logic push = txn_done_in && txn_ready_out && engine_enable_out;
    // clearing a done flag that is not raised pops nothing
    wire logic pop = wr_acc && paddr_in == 8'h08 && pwdata_in[3]
                     && done_sh_ff;

    always_comb
    begin
        nxt_occ = occ_ff + {2'h0, push} - {2'h0, pop};
        nxt_done_sh = occ_ff != 3'h0 && !pop && engine_enable_out;
        // a disabled engine has flushed its queue
        if (!engine_enable_out)
            nxt_occ = 3'h0;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            occ_ff     <= 3'h0;
            done_sh_ff <= 1'b0;
        end
        else
        begin
            occ_ff     <= nxt_occ;
            done_sh_ff <= nxt_done_sh;
        end
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    chk_queue_depth: assert property (
        engine_enable_out |-> txn_ready_out == (occ_ff < 3'h4))
        else $error("status queue depth wrong");
    chk_role_follow: assert property (
        wr_ctl |=> host_role_select_out == $past(pwdata_in[11])
        && engine_enable_out == $past(pwdata_in[8]))
        else $error("role or enable not taken from write");
    chk_bus_reset_gate: assert property (
        wr_ctl |=> drive_bus_reset_out ==
        ($past(pwdata_in[12]) && $past(pwdata_in[11])))
        else $error("bus reset drive wrong");
    chk_resume_follow: assert property (
        wr_ctl |=> drive_resume_out == $past(pwdata_in[10]))
        else $error("resume drive wrong");
    chk_ls_eop_time: assert property (
        $fell(drive_resume_out) && host_role_select_out
        |=> drive_ls_eop_out [*8] ##[EOP_LO:EOP_HI]
        $fell(drive_ls_eop_out))
        else $error("low speed end of packet missing");
    chk_sof_gate: assert property (
        sof_enable_out == (engine_enable_out && host_role_select_out))
        else $error("frame token enable wrong");
    chk_hold_release: assert property (
        wr_ctl && !pwdata_in[13] && !setup_rx_in |=> !traffic_halt_out)
        else $error("traffic halt not released");
    chk_odd_clear: assert property (
        wr_ctl && (pwdata_in[9] || !pwdata_in[8]) && !txn_done_in
        |=> odd_bank_out == {NUM_ENDPOINTS{1'b0}})
        else $error("ping-pong bits not cleared");
    chk_reserved_zero: assert property (
        psel_in && penable_in && !pwrite_in && paddr_in == 8'h04
        |-> prdata_out[1:0] == 2'h0 && prdata_out[31:16] == 16'h0)
        else $error("reserved bits not zero");
    chk_low_speed: assert property (
        wr_acc && paddr_in == 8'h06
        |=> low_speed_select_out == $past(pwdata_in[7]))
        else $error("low speed select wrong");

    cover property (txn_done_in && !txn_ready_out);
    cover property ($rose(drive_ls_eop_out));
    cover property ($rose(traffic_halt_out));
endmodule : eng_ctrl_chk

// [bench/usb_far_end.sv]
`timescale 1ns/1ps
module usb_far_end (
    // clock
    input  wire logic  clk_sys_in,
    // bus lines and engine events
    output logic       line_dp_out,
    output logic       line_dm_out,
    output logic       txn_done_out,
    output logic [3:0] txn_endpoint_out,
    output logic       txn_tx_out,
    output logic       txn_odd_out,
    output logic       setup_rx_out,
    output logic       token_start_out,
    output logic       token_end_out
);
    initial
    begin
        line_dp_out = 1'b0;
        line_dm_out = 1'b1;
        txn_done_out = 1'b0;
        txn_endpoint_out = 4'h0;
        txn_tx_out = 1'b0;
        txn_odd_out = 1'b0;
        {setup_rx_out, token_start_out, token_end_out} = 3'h0;
    end

    task automatic set_line(input logic dp, input logic dm);
        @(posedge clk_sys_in);
        line_dp_out <= dp;
        line_dm_out <= dm;
    endtask : set_line

    // pushes regardless of ready so a scenario can overfill the queue
    task automatic push(input logic [3:0] ep, input logic tx,
                        input logic odd);
        @(posedge clk_sys_in);
        txn_done_out <= 1'b1;
        txn_endpoint_out <= ep;
        txn_tx_out <= tx;
        txn_odd_out <= odd;
        @(posedge clk_sys_in);
        // status is only valid with the strobe, so scramble it after
        txn_done_out <= 1'b0;
        txn_endpoint_out <= ~ep;
        txn_tx_out <= ~tx;
        txn_odd_out <= ~odd;
    endtask : push

    task automatic pulse(input logic [2:0] which);
        @(posedge clk_sys_in);
        {setup_rx_out, token_start_out, token_end_out} <= which;
        @(posedge clk_sys_in);
        {setup_rx_out, token_start_out, token_end_out} <= 3'h0;
    endtask : pulse
endmodule : usb_far_end

// [bench/usb_sie_control_status_fifo_tb_top.sv]
`timescale 1ns/1ps
module usb_sie_control_status_fifo_tb_top;
    import eng_status_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic [3:0]  txn_endpoint_in;
    logic [15:0] odd_bank_out;
    logic        pready_out, pslverr_out, line_dp_in, line_dm_in;
    logic        txn_done_in, txn_tx_in, txn_odd_in, txn_ready_out;
    logic        setup_rx_in, token_start_in, token_end_in;
    logic        engine_enable_out, host_role_select_out;
    logic        drive_bus_reset_out, drive_resume_out, drive_ls_eop_out;
    logic        traffic_halt_out, sof_enable_out, low_speed_select_out;
    logic        last_err;
    int          err_total = 0;
    int          n_compared = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    eng_control_status #(.NUM_ENDPOINTS(16)) DUT (.*);

    usb_far_end far (
        .clk_sys_in       (clk_sys_in),
        .line_dp_out      (line_dp_in),
        .line_dm_out      (line_dm_in),
        .txn_done_out     (txn_done_in),
        .txn_endpoint_out (txn_endpoint_in),
        .txn_tx_out       (txn_tx_in),
        .txn_odd_out      (txn_odd_in),
        .setup_rx_out     (setup_rx_in),
        .token_start_out  (token_start_in),
        .token_end_out    (token_end_in)
    );

    // ********
    // shared tasks
    // ********
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        // only the watchdog ends a wait that never sees ready
        while (pready_out !== 1'b1)
            @(posedge clk_sys_in);
        rd = prdata_out;
        last_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        apb(1'b1, addr, wd, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask,
                          input logic [31:0] exp);
        logic [31:0] rd;
        apb(1'b0, addr, 32'h0, rd);
        check(rd & mask, exp);
    endtask : rd_chk

    task automatic line_case(input logic dp, input logic dm,
                             input logic [31:0] exp);
        far.set_line(dp, dm);
        // two-flop synchroniser plus margin
        repeat (4) @(posedge clk_sys_in);
        rd_chk(8'h04, 32'h0000C000, exp);
    endtask : line_case

    // ********
    // scenarios
    // ********
    task automatic t_reset;
        rd_chk(8'h04, 32'hFFFFFFFF, {16'h0, CTRL_STATUS_RESET});
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
        check({31'h0, last_err}, 32'h1);
    endtask : t_reset

    task automatic t_lines;
        line_case(1'b1, 1'b0, 32'h00008000);
        line_case(1'b0, 1'b0, 32'h00004000);
        wr(8'h06, 32'h80);
        line_case(1'b0, 1'b1, 32'h00008000);
        wr(8'h06, 32'h0);
    endtask : t_lines

    task automatic t_fifo;
        wr(8'h04, 32'h0100);
        for (int i = 1; i <= 5; i++)
            far.push(i[3:0], i[0], i[1]);
        @(negedge clk_sys_in);
        check({31'h0, txn_ready_out}, 32'h0);
        check({16'h0, odd_bank_out}, 32'h1E);
        for (int i = 1; i <= 4; i++)
        begin
            rd_chk(8'h08, 32'h8, 32'h8);
            rd_chk(8'h04, 32'hFF, {i[3:0], i[0], i[1], 2'b00});
            wr(8'h08, 32'h8);
        end
        rd_chk(8'h08, 32'h8, 32'h0);
        rd_chk(8'h04, 32'hFC, 32'h0);
        wr(8'h04, 32'h0300);
        @(negedge clk_sys_in);
        check({16'h0, odd_bank_out}, 32'h0);
    endtask : t_fifo

    task automatic t_periph;
        wr(8'h04, 32'h0100);
        far.pulse(3'b100);
        rd_chk(8'h04, 32'h2000, 32'h2000);
        check({31'h0, traffic_halt_out}, 32'h1);
        wr(8'h04, 32'h1100);
        @(negedge clk_sys_in);
        check({30'h0, drive_bus_reset_out, host_role_select_out}, 32'h0);
        check({31'h0, traffic_halt_out}, 32'h0);
    endtask : t_periph

    task automatic t_host;
        int n;
        wr(8'h04, 32'h1900);
        @(negedge clk_sys_in);
        check({30'h0, drive_bus_reset_out, sof_enable_out}, 32'h3);
        wr(8'h04, 32'h0900);
        rd_chk(8'h04, 32'h2000, 32'h0);
        far.pulse(3'b010);
        rd_chk(8'h04, 32'h2000, 32'h2000);
        far.pulse(3'b001);
        rd_chk(8'h04, 32'h2000, 32'h0);
        wr(8'h04, 32'h0D00);
        @(negedge clk_sys_in);
        check({31'h0, drive_resume_out}, 32'h1);
        wr(8'h04, 32'h0900);
        n = 0;
        while (drive_ls_eop_out !== 1'b1 && n < 300)
        begin
            n++;
            @(negedge clk_sys_in);
        end
        check({31'h0, drive_ls_eop_out}, 32'h1);
        far.push(4'h7, 1'b1, 1'b1);
        wr(8'h04, 32'h0800);
        @(negedge clk_sys_in);
        check({15'h0, sof_enable_out, odd_bank_out}, 32'h0);
        rd_chk(8'h08, 32'h8, 32'h0);
    endtask : t_host

    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        t_reset();
        t_lines();
        t_fifo();
        t_periph();
        t_host();
        close_out();
    end

    initial
    begin
        #500000;
        err_total++;
        close_out();
    end
endmodule : usb_sie_control_status_fifo_tb_top

bind eng_control_status eng_ctrl_chk #(.NUM_ENDPOINTS(NUM_ENDPOINTS))
    u_chk (.*);
